// ---- src/eps_top.sv ----
// program/erase sequencer with axi4-lite register and array access
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eps_defs.svh"
module eps_top
  import eps_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // mode pins
  input wire logic mode_special_i,
  input wire logic mode_expanded_i,
  // axi4-lite write address
  input wire logic [15:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [15:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // device side
  output logic hv_on_o,
  output logic pump_clock_select_o,
  output logic [7:0] config_o,
  output logic secure_o,
  output logic mode_expanded_o
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] spec_sync;
  logic [1:0] exp_sync;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spec_sync <= 2'b00;
      exp_sync <= 2'b00;
    end else begin
      spec_sync <= {spec_sync[0], mode_special_i};
      exp_sync <= {exp_sync[0], mode_expanded_i};
    end
  end
  wire special_mode = spec_sync[1];

  // ==========================================================
  // axi4-lite handshakes
  logic aw_held;
  logic w_held;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  wire w_fire = s_axi_wvalid_i && s_axi_wready_o;
  wire b_fire = s_axi_bvalid_o && s_axi_bready_i;
  wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  wire r_fire = s_axi_rvalid_o && s_axi_rready_i;
  wire wr_do = aw_held && w_held && !s_axi_bvalid_o;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      awaddr_q <= 16'h0000;
      s_axi_awready_o <= 1'b1;
    end else if (aw_fire) begin
      aw_held <= 1'b1;
      awaddr_q <= s_axi_awaddr_i;
      s_axi_awready_o <= 1'b0;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end else if (b_fire) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_held <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      s_axi_wready_o <= 1'b1;
    end else if (w_fire) begin
      w_held <= 1'b1;
      wdata_q <= s_axi_wdata_i;
      wstrb0_q <= s_axi_wstrb_i[0];
      s_axi_wready_o <= 1'b0;
    end else if (wr_do) begin
      w_held <= 1'b0;
    end else if (b_fire) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  // ==========================================================
  // write decode
  wire wa_arr = (awaddr_q < `EPS_ARR_END) && (awaddr_q[1:0] == 2'b00);
  wire wa_pctl = (awaddr_q == `EPS_ADDR_PCTL);
  wire wa_block_protect_reg = (awaddr_q == `EPS_ADDR_BLOCK_PROTECT_REG);
  wire wa_opt = (awaddr_q == `EPS_ADDR_OPTION);
  wire wa_cfg = (awaddr_q == `EPS_ADDR_CONFIG);
  wire wa_stat = (awaddr_q == `EPS_ADDR_STATUS);
  wire wa_hit = wa_arr || wa_pctl || wa_block_protect_reg || wa_opt || wa_cfg || wa_stat;
  wire wr_en = wr_do && wstrb0_q;
  wire wr_pctl = wr_en && wa_pctl;
  wire [7:0] wd = wdata_q[7:0];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `EPS_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wa_hit ? `EPS_RESP_OKAY : `EPS_RESP_SLVERR;
    end else if (b_fire) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ==========================================================
  // control register
  logic [7:0] pctl;
  logic [7:0] next_pctl;
  wire lat_now = pctl[`EPS_PC_LAT];
  wire hv_now = pctl[`EPS_PC_HV];
  wire [7:0] wd_m = wd & `EPS_PC_MASK;
  wire [7:0] hv_only = 8'h01 << `EPS_PC_HV;
  wire [7:0] lat_only = 8'h01 << `EPS_PC_LAT;
  // voltage needs a latch already in place, so a combined write cannot
  // skip the store that names the target
  assign next_pctl = (wd_m == 8'h00) ? 8'h00 :
    (!lat_now && wd_m[`EPS_PC_HV] && wd_m[`EPS_PC_LAT]) ? (wd_m & ~(hv_only | lat_only)) :
    (!lat_now) ? (wd_m & ~hv_only) :
    (!hv_now && !wd_m[`EPS_PC_LAT]) ? (wd_m & ~hv_only) :
    (hv_now) ? (wd_m | lat_only) :
    wd_m;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pctl <= 8'h00;
    end else if (wr_pctl) begin
      pctl <= next_pctl;
    end
  end
  assign hv_on_o = pctl[`EPS_PC_HV];

  // ==========================================================
  // latched target of the programming store
  logic addr_valid;
  logic tgt_cfg;
  logic [8:0] lat_idx;
  eps_byte_t lat_data;
  wire store_ok = wr_en && lat_now && !hv_now && (wa_arr || wa_cfg);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_valid <= 1'b0;
      tgt_cfg <= 1'b0;
      lat_idx <= 9'h000;
      lat_data <= 8'h00;
    end else if (wr_pctl && !next_pctl[`EPS_PC_LAT]) begin
      addr_valid <= 1'b0;
    end else if (store_ok) begin
      addr_valid <= 1'b1;
      tgt_cfg <= wa_cfg;
      lat_idx <= awaddr_q[10:2];
      lat_data <= wd;
    end
  end

  // the operation fires once, on the write that turns the voltage on
  wire hv_rise = wr_pctl && !hv_now && next_pctl[`EPS_PC_HV] && addr_valid;
  wire op_erase = next_pctl[`EPS_PC_ERASE];
  eps_op_e op;
  assign op = !op_erase ? EPS_OP_PROG :
    next_pctl[`EPS_PC_BYTE] ? EPS_OP_BYTE :
    next_pctl[`EPS_PC_ROW] ? EPS_OP_ROW :
    EPS_OP_BULK;

  // ==========================================================
  // block protect, option
  logic [4:0] block_protect_reg;
  logic [6:0] win_cnt;
  logic [7:0] option;
  wire win_open = (win_cnt < `EPS_BP_WINDOW);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_cnt <= 7'h00;
    end else if (win_open) begin
      win_cnt <= win_cnt + 7'h01;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      block_protect_reg <= `EPS_BP_RESET;
    end else if (wr_en && wa_block_protect_reg) begin
      block_protect_reg <= (special_mode || win_open) ? wd[4:0] : (block_protect_reg | wd[4:0]);
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      option <= 8'h00;
    end else if (wr_en && wa_opt) begin
      option <= wd;
    end
  end
  assign pump_clock_select_o = option[`EPS_OPT_PUMP_CLOCK_SELECT];

  function automatic logic blk_locked(input logic [8:0] idx, input logic [4:0] bp);
    if (idx < `EPS_BLK0_END) blk_locked = bp[0];
    else if (idx < `EPS_BLK1_END) blk_locked = bp[1];
    else if (idx < `EPS_BLK2_END) blk_locked = bp[2];
    else blk_locked = bp[3];
  endfunction

  // ==========================================================
  // array and configuration cells (nonvolatile, no reset)
  eps_byte_t mem [0:`EPS_ARR_DEPTH-1];
  eps_byte_t config_nv;
  for (genvar gi = 0; gi < `EPS_ARR_DEPTH; gi++) begin : g_cell
    wire [8:0] ci = 9'(gi);
    wire row_hit = (ci[`EPS_ROW_MSB:`EPS_ROW_LSB] == lat_idx[`EPS_ROW_MSB:`EPS_ROW_LSB]);
    wire hit = (op == EPS_OP_BULK) || ((op == EPS_OP_ROW) ? row_hit : (ci == lat_idx));
    always_ff @(posedge clk_i) begin
      if (hv_rise && !tgt_cfg && hit && !blk_locked(ci, block_protect_reg)) begin
        mem[gi] <= op_erase ? `EPS_ERASED : (mem[gi] & lat_data);
      end
    end
  end
  // bulk erase targets only the array; config needs its own store
  always_ff @(posedge clk_i) begin
    if (hv_rise && tgt_cfg && !block_protect_reg[`EPS_BP_CONFIG_PROTECT_BIT]) begin
      config_nv <= op_erase ? `EPS_ERASED : (config_nv & lat_data);
    end
  end

  // ==========================================================
  // active configuration, taken once after reset release
  logic cfg_loaded;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_loaded <= 1'b0;
      config_o <= `EPS_CFG_DEFAULT;
    end else if (!cfg_loaded) begin
      cfg_loaded <= 1'b1;
      config_o <= config_nv;
    end
  end
  // security only gates the external mode, internal access is untouched
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      secure_o <= 1'b0;
      mode_expanded_o <= 1'b0;
    end else begin
      secure_o <= cfg_loaded && !config_o[`EPS_CFG_SEC];
      mode_expanded_o <= exp_sync[1] && !(cfg_loaded && !config_o[`EPS_CFG_SEC]);
    end
  end

  // ==========================================================
  // read path
  wire ra_arr = (s_axi_araddr_i < `EPS_ARR_END) && (s_axi_araddr_i[1:0] == 2'b00);
  wire ra_pctl = (s_axi_araddr_i == `EPS_ADDR_PCTL);
  wire ra_block_protect_reg = (s_axi_araddr_i == `EPS_ADDR_BLOCK_PROTECT_REG);
  wire ra_opt = (s_axi_araddr_i == `EPS_ADDR_OPTION);
  wire ra_cfg = (s_axi_araddr_i == `EPS_ADDR_CONFIG);
  wire ra_stat = (s_axi_araddr_i == `EPS_ADDR_STATUS);
  wire [7:0] status = {4'h0, addr_valid, win_open, secure_o, special_mode};
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (ra_arr) begin
      rd_byte = lat_now ? 8'h00 : mem[s_axi_araddr_i[10:2]];
    end else if (ra_pctl) begin
      rd_byte = pctl;
    end else if (ra_block_protect_reg) begin
      rd_byte = {3'b000, block_protect_reg};
    end else if (ra_opt) begin
      rd_byte = option;
    end else if (ra_cfg) begin
      rd_byte = lat_now ? 8'h00 : config_nv;
    end else if (ra_stat) begin
      rd_byte = status;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `EPS_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h00_0000, rd_byte};
      s_axi_rresp_o <= rd_hit ? `EPS_RESP_OKAY : `EPS_RESP_SLVERR;
    end else if (r_fire) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_hv_needs_latch: assert property (hv_on_o |-> pctl[`EPS_PC_LAT])
    else $error("voltage on without latch");
  a_combined_refused: assert property (wr_pctl && !lat_now && wd[0] && wd[1]
    |=> !hv_on_o && !pctl[`EPS_PC_LAT])
    else $error("combined latch and voltage write took effect");
  a_zero_clears_all: assert property (wr_pctl && wd == 8'h00 |=> pctl == 8'h00 && !hv_on_o)
    else $error("zero write left control bits");
  a_block_protect_reg_set_only: assert property (!win_open && !special_mode
    |=> ($past(block_protect_reg) & ~block_protect_reg) == 5'h00)
    else $error("block protect bit cleared after window");
  a_block_protect_reg_reset_ones: assert property (win_cnt == 7'h00 |-> block_protect_reg == `EPS_BP_RESET)
    else $error("block protect not all ones after reset");
  a_cfg_protected: assert property (hv_rise && tgt_cfg && block_protect_reg[`EPS_BP_CONFIG_PROTECT_BIT]
    |=> config_nv == $past(config_nv))
    else $error("protected configuration word changed");
  a_array_op_keeps_cfg: assert property (hv_rise && !tgt_cfg |=> $stable(config_nv))
    else $error("array operation changed configuration word");
  a_latched_read_blank: assert property (ar_fire && ra_arr && lat_now
    |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h0000_0000)
    else $error("array read returned data while latched");
  a_secure_single_chip: assert property (secure_o |=> !mode_expanded_o)
    else $error("expanded mode while secure");
  a_cfg_after_reset: assert property (cfg_loaded ##1 cfg_loaded |-> $stable(config_o))
    else $error("active configuration changed without reset");

  c_byte_program: cover property (hv_rise && op == EPS_OP_PROG);
  c_row_erase: cover property (hv_rise && op == EPS_OP_ROW);
  c_bulk_erase: cover property (hv_rise && op == EPS_OP_BULK);
  c_cfg_write: cover property (hv_rise && tgt_cfg && !block_protect_reg[`EPS_BP_CONFIG_PROTECT_BIT]);

endmodule

// ---- src/eps_defs.svh ----
// constants for the nonvolatile program/erase sequencer
// ==========================================================
`ifndef EPS_DEFS_SVH
`define EPS_DEFS_SVH
// register indices as printed; byte address is four times the index
`define EPS_IDX_PCTL 16'h103B
`define EPS_IDX_BLOCK_PROTECT_REG 16'h1035
`define EPS_IDX_OPTION 16'h1039
`define EPS_IDX_CONFIG 16'h103F
`define EPS_IDX_STATUS 16'h1030
`define EPS_ADDR_PCTL 16'h40EC
`define EPS_ADDR_BLOCK_PROTECT_REG 16'h40D4
`define EPS_ADDR_OPTION 16'h40E4
`define EPS_ADDR_CONFIG 16'h40FC
`define EPS_ADDR_STATUS 16'h40C0
// array window: one byte per word from address zero
`define EPS_ARR_END 16'h0800
`define EPS_ARR_DEPTH 512
// control register field positions
`define EPS_PC_HV 0
`define EPS_PC_LAT 1
`define EPS_PC_ERASE 2
`define EPS_PC_ROW 3
`define EPS_PC_BYTE 4
`define EPS_PC_MASK 8'h1F
// block protect
`define EPS_BP_CONFIG_PROTECT_BIT 4
`define EPS_BP_RESET 5'h1F
`define EPS_BP_WINDOW 7'h40
`define EPS_BLK0_END 9'h020
`define EPS_BLK1_END 9'h060
`define EPS_BLK2_END 9'h0E0
// option and configuration
`define EPS_OPT_PUMP_CLOCK_SELECT 6
`define EPS_CFG_SEC 3
`define EPS_CFG_DEFAULT 8'hFF
// row field of an array index (16-byte rows)
`define EPS_ROW_MSB 8
`define EPS_ROW_LSB 4
`define EPS_ERASED 8'hFF
// axi responses
`define EPS_RESP_OKAY 2'b00
`define EPS_RESP_SLVERR 2'b10
`endif

// ---- src/eps_pkg.sv ----
// types shared by the program/erase sequencer
package eps_pkg;
  typedef logic [7:0] eps_byte_t;
  typedef enum logic [1:0] {EPS_OP_PROG, EPS_OP_BULK, EPS_OP_ROW, EPS_OP_BYTE} eps_op_e;
endpackage

// ---- bench/eps_testbench.sv ----
// self-checking bench for the program/erase sequencer
`timescale 1ns/1ps
`include "eps_defs.svh"
module testbench
  import eps_pkg::*;
;
  // ==========================================================
  // signals and device
  typedef struct {
    logic [7:0] c;
    logic [15:0] a;
    logic [7:0] d;
    logic [15:0] ca;
    logic [7:0] e;
  } eps_row_s;
  logic clk_i, reset_n_i, mode_special_i, mode_expanded_i;
  logic [15:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_d;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic hv_on_o, pump_clock_select_o, secure_o, mode_expanded_o;
  logic [7:0] config_o;
  int bad_count, check_count;
  // control value 0 means a read-only row; each sequence ends in a clear
  eps_row_s rows [19] = '{
    '{8'h06, 16'h0000, 8'h55, 16'h07FC, 8'hFF}, '{8'h00, 16'h0000, 8'h00, 16'h0000, 8'hFF},
    '{8'h02, 16'h0040, 8'hA5, 16'h0040, 8'hA5}, '{8'h02, 16'h0040, 8'h5A, 16'h0040, 8'h00},
    '{8'h1A, 16'h0044, 8'h0F, 16'h0044, 8'h0F}, '{8'h00, 16'h0000, 8'h00, 16'h0040, 8'h00},
    '{8'h02, 16'h0080, 8'h3C, 16'h0080, 8'h3C}, '{8'h02, 16'h003C, 8'hC3, 16'h003C, 8'hC3},
    '{8'h0E, 16'h0078, 8'h00, 16'h0040, 8'hFF}, '{8'h00, 16'h0000, 8'h00, 16'h0044, 8'hFF},
    '{8'h00, 16'h0000, 8'h00, 16'h0080, 8'h3C}, '{8'h00, 16'h0000, 8'h00, 16'h003C, 8'hC3},
    '{8'h02, 16'h0084, 8'h11, 16'h0084, 8'h11}, '{8'h16, 16'h0084, 8'h00, 16'h0084, 8'hFF},
    '{8'h00, 16'h0000, 8'h00, 16'h0080, 8'h3C}, '{8'h16, 16'h40FC, 8'h00, 16'h40FC, 8'hFF},
    '{8'h02, 16'h40FC, 8'hF7, 16'h40FC, 8'hF7}, '{8'h06, 16'h0100, 8'h00, 16'h40FC, 8'hF7},
    '{8'h00, 16'h0000, 8'h00, 16'h0080, 8'hFF}
  };

  eps_top u_eps_top (
    .clk_i, .reset_n_i, .mode_special_i, .mode_expanded_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .hv_on_o, .pump_clock_select_o, .config_o, .secure_o, .mode_expanded_o
  );

  always #12.5 clk_i = ~clk_i;

  // ==========================================================
  // bus and check tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // bready goes up with the request, so the answer is taken at the edge it is seen
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h00_0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awvalid_i && s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      print_verdict();
    end
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [15:0] a);
    int n;
    n = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arvalid_i && s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      print_verdict();
    end
    rd_d = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // latch, store, voltage on, clear: the software order for every operation
  task automatic seq(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    wr(`EPS_ADDR_PCTL, c);
    wr(a, d);
    rd(a);
    chk("latched read", rd_d, 32'h0000_0000);
    wr(`EPS_ADDR_PCTL, c | 8'h01);
    chk("hv on", hv_on_o, 1'b1);
    rd(`EPS_ADDR_PCTL);
    chk("control bits", rd_d, {24'h00_0000, c | 8'h01});
    wr(`EPS_ADDR_PCTL, 8'h00);
    chk("hv off", hv_on_o, 1'b0);
  endtask

  task automatic rst();
    reset_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // secure settles two edges and granted mode three edges after release
    repeat (4) @(posedge clk_i);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    mode_special_i = 1'b0;
    mode_expanded_i = 1'b0;
    s_axi_awaddr_i = 16'h0000;
    s_axi_araddr_i = 16'h0000;
    s_axi_wdata_i = 32'h0000_0000;
    s_axi_wstrb_i = 4'h1;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
    bad_count = 0;
    check_count = 0;
    @(posedge clk_i);
    rst();
    chk("hv after reset", hv_on_o, 1'b0);
    rd(`EPS_ADDR_PCTL);
    chk("control reset", rd_d, 32'h0000_0000);
    rd(`EPS_ADDR_BLOCK_PROTECT_REG);
    chk("protect reset", rd_d, 32'h0000_001F);
    wr(`EPS_ADDR_BLOCK_PROTECT_REG, 8'h00);
    rd(`EPS_ADDR_BLOCK_PROTECT_REG);
    chk("protect cleared", rd_d, 32'h0000_0000);
    wr(`EPS_ADDR_OPTION, 8'h40);
    chk("pump clock", pump_clock_select_o, 1'b1);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].c != 8'h00) seq(rows[i].c, rows[i].a, rows[i].d);
      rd(rows[i].ca);
      chk("cell", rd_d, {24'h00_0000, rows[i].e});
    end
    $display("test table done");
    wr(`EPS_ADDR_PCTL, 8'h03);
    rd(`EPS_ADDR_PCTL);
    chk("latch and hv together", rd_d, 32'h0000_0000);
    chk("hv stays off", hv_on_o, 1'b0);
    wr(16'h5000, 8'h00);
    chk("unmapped write resp", rsp, 2'b10);
    rd(16'h5000);
    chk("unmapped read resp", rsp, 2'b10);
    chk("unmapped read data", rd_d, 32'h0000_0000);
    $display("test refusals done");
    wr(`EPS_ADDR_BLOCK_PROTECT_REG, 8'h10);
    wr(`EPS_ADDR_BLOCK_PROTECT_REG, 8'h00);
    rd(`EPS_ADDR_BLOCK_PROTECT_REG);
    chk("protect late clear", rd_d, 32'h0000_0010);
    seq(8'h16, `EPS_ADDR_CONFIG, 8'h00);
    rd(`EPS_ADDR_CONFIG);
    chk("config protected", rd_d, 32'h0000_00F7);
    mode_special_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr(`EPS_ADDR_BLOCK_PROTECT_REG, 8'h00);
    rd(`EPS_ADDR_BLOCK_PROTECT_REG);
    chk("protect special clear", rd_d, 32'h0000_0000);
    mode_special_i <= 1'b0;
    $display("test protect done");
    mode_expanded_i <= 1'b1;
    rst();
    chk("config loaded", config_o, 8'hF7);
    chk("secure", secure_o, 1'b1);
    chk("expanded refused", mode_expanded_o, 1'b0);
    wr(`EPS_ADDR_BLOCK_PROTECT_REG, 8'h00);
    rd(16'h0080);
    chk("secure array read", rd_d, 32'h0000_00FF);
    seq(8'h16, `EPS_ADDR_CONFIG, 8'h00);
    rd(`EPS_ADDR_CONFIG);
    chk("config erased", rd_d, 32'h0000_00FF);
    chk("config held", config_o, 8'hF7);
    rst();
    chk("config new", config_o, 8'hFF);
    chk("not secure", secure_o, 1'b0);
    chk("expanded granted", mode_expanded_o, 1'b1);
    $display("test security done");
    print_verdict();
  end
endmodule
